/* File: src/clkgen_pkg.sv */
/*
 CPU clock generation select: shared constants and mode encodings.
 Assumes one system clock that samples the oscillator and reset pins.
*/
// Behaviour
// - Both CPU clock edges usable; half-period unit.
// - Mode field is latch bits 7 to 5.
// - Long reset loads latch from port0 upper byte.
// - Software may reload latch from control register.
// - 111 x4 default, 110 x3, 101 x2, 100 x5.
// - 011 direct, 010 x1.5, 001 half, 000 x2.5.
// - Prescaler phases each one oscillator period.
// - PLL multiplies, resyncs every den-th transition.
// - PLL accumulated shortfall bounded by jitter formula.
// - Direct drive passes oscillator straight through.
package clkgen_pkg;
    localparam int          CFG_W         = 8;
    localparam int          MODE_MSB      = 7;
    localparam int          MODE_LSB      = 5;
    localparam logic [7:0]  CFG_RESET     = 8'hFF;
    localparam logic [2:0]  MODE_X4       = 3'h7;
    localparam logic [2:0]  MODE_X3       = 3'h6;
    localparam logic [2:0]  MODE_X2       = 3'h5;
    localparam logic [2:0]  MODE_X5       = 3'h4;
    localparam logic [2:0]  MODE_DIRECT   = 3'h3;
    localparam logic [2:0]  MODE_X1P5     = 3'h2;
    localparam logic [2:0]  MODE_PRESCALE = 3'h1;
    localparam logic [2:0]  MODE_X2P5     = 3'h0;
    // Multiplication factor as numerator / denominator over oscillator half-periods
    localparam int          PH_W          = 16;
    localparam logic [15:0] PH_STEP_DEF   = 16'h0100;
    // Minimum idle cycles between two multiplied toggles; bounds half-period shortfall
    localparam int          PACE_GAP      = 3;
    // Quiet count after a source change; the CPU clock is held low at least two cycles beyond it
    localparam int          QUIET_CYC     = 2;
endpackage

/* File: src/clk_phase_gen.sv */
/*
 Fractional CPU clock phase generator (digital model of the PLL).
 Assumes osc_edge_i marks each oscillator transition, sampled on clk_sys_i.
*/
`timescale 1ns/1ps
module clk_phase_gen (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_b_i,
    input  wire logic       osc_edge_i,
    input  wire logic [2:0] num_i,
    input  wire logic [2:0] den_i,
    output logic            toggle_o
);
    import clkgen_pkg::*;
    // Credit of pending toggles in units of 1/den; each transition adds num.
    // Credit is whole again after every den-th transition, so the output
    // re-locks to the oscillator there with no abrupt jump in rate.
    logic [3:0] credit;
    logic [1:0] gap;
    logic [3:0] next_credit;
    logic [1:0] next_gap;
    wire  [3:0] den_w   = {1'b0, den_i};
    wire        fire    = (credit >= den_w) && (gap == 2'h0);
    wire  [3:0] drained = fire ? credit - den_w : credit;
    assign next_credit = osc_edge_i ? drained + {1'b0, num_i} : drained;
    // Pacing spreads toggles over the half-period instead of bunching them
    assign next_gap    = fire ? 2'(PACE_GAP) : ((gap != 2'h0) ? gap - 2'h1 : 2'h0);
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            credit   <= 4'h0;
            gap      <= 2'h0;
            toggle_o <= 1'b0;
        end else begin
            toggle_o <= fire;
            credit   <= next_credit;
            gap      <= next_gap;
        end
    end

    pll_pace_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        toggle_o |=> !toggle_o [*3])
        else $error("multiplied toggles too close");
endmodule

/* File: src/cpu_clock_generation_select.sv */
/*
 CPU clock source selection: reset configuration latch, mode decode,
 direct, prescaler and multiplied paths, glitch-free switchover.
 Assumes osc_i is far slower than clk_sys_i so every transition is seen.
*/
`timescale 1ns/1ps
module cpu_clock_generation_select (
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  osc_i,
    input  wire logic                  long_reset_i,
    input  wire logic [7:0]            port0_upper_byte_i,
    input  wire logic                  cfg_load_i,
    input  wire logic [7:0]            reset_control_register_i,
    output logic [7:0]                 reset_config_latch_o,
    output logic [2:0]                 clock_mode_select_o,
    output logic                       cpu_clk_o,
    output logic                       half_period_edge_o
);
    import clkgen_pkg::*;

    logic       rst_s1;
    logic       rst_s;
    logic [1:0] osc_sync;
    logic       osc_d;
    logic [7:0] pin_s1;
    logic [7:0] pin_s;
    logic       lr_s1;
    logic       lr_s;
    logic       ld_s1;
    logic       ld_s;
    logic       ld_d;
    logic [7:0] cfg;
    logic [2:0] active_mode;
    logic       pending;
    logic       cpu_clk;
    logic       cpu_clk_d;
    logic [2:0] num;
    logic [2:0] den;
    logic       pll_toggle;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1 <= 1'b0;
            rst_s  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s  <= rst_s1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_s) begin
        if (!rst_s) begin
            osc_sync <= 2'h0;
            osc_d    <= 1'b0;
            pin_s1   <= 8'h00;
            pin_s    <= 8'h00;
            lr_s1    <= 1'b0;
            lr_s     <= 1'b0;
            ld_s1    <= 1'b0;
            ld_s     <= 1'b0;
            ld_d     <= 1'b0;
        end else begin
            osc_sync <= {osc_sync[0], osc_i};
            osc_d    <= osc_sync[1];
            pin_s1   <= port0_upper_byte_i;
            pin_s    <= pin_s1;
            lr_s1    <= long_reset_i;
            lr_s     <= lr_s1;
            ld_s1    <= cfg_load_i;
            ld_s     <= ld_s1;
            ld_d     <= ld_s;
        end
    end

    wire osc_edge = osc_sync[1] ^ osc_d;
    wire osc_rise = osc_sync[1] & ~osc_d;
    wire sw_load  = ld_s & ~ld_d;

    // Latch follows the pins throughout a long reset; last value before release stays
    always_ff @(posedge clk_sys_i or negedge rst_s) begin
        if (!rst_s) begin
            cfg <= CFG_RESET;
        end else if (lr_s) begin
            cfg <= pin_s;
        end else if (sw_load) begin
            cfg <= reset_control_register_i;
        end
    end

    wire [2:0] mode_field = cfg[MODE_MSB:MODE_LSB];

    // Ratio table: CPU toggles per oscillator transitions
    assign num = (active_mode == MODE_X4)   ? 3'h4 :
                 (active_mode == MODE_X3)   ? 3'h3 :
                 (active_mode == MODE_X2)   ? 3'h2 :
                 (active_mode == MODE_X5)   ? 3'h5 :
                 (active_mode == MODE_X1P5) ? 3'h3 :
                 (active_mode == MODE_X2P5) ? 3'h5 : 3'h1;
    assign den = (active_mode == MODE_X1P5) ? 3'h2 :
                 (active_mode == MODE_X2P5) ? 3'h2 : 3'h1;

    wire is_direct = (active_mode == MODE_DIRECT);
    wire is_pre    = (active_mode == MODE_PRESCALE);

    clk_phase_gen u_phase (
        .clk_sys_i  (clk_sys_i),
        .rst_b_i    (rst_s),
        .osc_edge_i (osc_edge),
        .num_i      (num),
        .den_i      (den),
        .toggle_o   (pll_toggle)
    );

    // Model limitation: multiplied edges are stretched onto the system clock grid
    wire next_cpu_clk = is_direct ? osc_sync[1] :
                        is_pre    ? (osc_rise ? ~cpu_clk : cpu_clk) :
                        (pll_toggle ? ~cpu_clk : cpu_clk);

    // Source change: switch only in a low phase, then hold low a few cycles,
    // and for direct drive also until the oscillator is low, so that neither
    // the last old phase nor the first new one can be a runt.
    logic       gate;
    logic [1:0] quiet;
    wire        do_switch  = pending && !cpu_clk && !gate;
    wire        gate_clear = (quiet == 2'h0) && (!is_direct || !osc_sync[1]);
    wire  [1:0] next_quiet = do_switch ? 2'(QUIET_CYC) :
                             ((quiet != 2'h0) ? quiet - 2'h1 : 2'h0);

    always_ff @(posedge clk_sys_i or negedge rst_s) begin
        if (!rst_s) begin
            active_mode <= MODE_X4;
            pending     <= 1'b0;
            gate        <= 1'b0;
            quiet       <= 2'h0;
            cpu_clk     <= 1'b0;
            cpu_clk_d   <= 1'b0;
        end else begin
            pending   <= (mode_field != active_mode);
            quiet     <= next_quiet;
            gate      <= do_switch || (gate && !gate_clear);
            cpu_clk   <= (do_switch || gate) ? 1'b0 : next_cpu_clk;
            cpu_clk_d <= cpu_clk;
            if (do_switch) begin
                active_mode <= mode_field;
            end
        end
    end

    assign reset_config_latch_o = cfg;
    assign clock_mode_select_o  = active_mode;
    assign cpu_clk_o            = cpu_clk;
    assign half_period_edge_o   = cpu_clk ^ cpu_clk_d;

    prescale_phase_a: assert property (@(posedge clk_sys_i) disable iff (!rst_s)
        is_pre && !pending && !gate && osc_rise |=> cpu_clk != $past(cpu_clk))
        else $error("prescaler missed toggle");

    direct_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rst_s)
        is_direct && !pending && !gate && $stable(active_mode)
        |=> cpu_clk == $past(osc_sync[1]))
        else $error("direct drive not following");

    long_load_a: assert property (@(posedge clk_sys_i) disable iff (!rst_s)
        lr_s |=> cfg == $past(pin_s))
        else $error("latch not loaded from pins");

    soft_load_a: assert property (@(posedge clk_sys_i) disable iff (!rst_s)
        sw_load && !lr_s |=> cfg == $past(reset_control_register_i))
        else $error("latch not loaded by software");

    mode_switch_a: assert property (@(posedge clk_sys_i) disable iff (!rst_s)
        $changed(active_mode) |-> !cpu_clk)
        else $error("mode switched in high phase");

    mode_source_a: assert property (@(posedge clk_sys_i) disable iff (!rst_s)
        $changed(active_mode) |-> active_mode == $past(mode_field))
        else $error("mode not taken from latch field");

    gate_low_a: assert property (@(posedge clk_sys_i) disable iff (!rst_s)
        gate |-> !cpu_clk)
        else $error("clock high while source gated");
endmodule

/* File: test/osc_source.sv */
/*
 Free-running oscillator standing in for the crystal or external source.
 Assumes nothing of the block; uneven duty and an odd start phase on purpose.
*/
`timescale 1ns/1ps
module osc_source #(
    parameter int HI_NS = 600,
    parameter int LO_NS = 1000
) (
    output logic osc_o
);
    // Offset keeps edges away from the system clock edges
    initial begin
        osc_o = 1'b0;
        #7;
        forever begin
            osc_o = 1'b1;
            #HI_NS;
            osc_o = 1'b0;
            #LO_NS;
        end
    end
endmodule

/* File: test/tb_cpu_clock_generation_select.sv */
/*
 Self-checking bench for cpu_clock_generation_select.
 Assumes osc_source runs 30 cycles high, 50 low against a 20 ns system clock.
*/
`timescale 1ns/1ps
module tb_cpu_clock_generation_select;
    import clkgen_pkg::*;
    logic       clk_sys_i, rst_b_i, osc_i, long_reset_i, cfg_load_i, cpu_clk, hp_edge, cpu_q;
    logic [7:0] port0_upper_byte_i, reset_control_register_i, latch;
    logic [2:0] mode;
    int         errors, checks_done, cyc, toggles, pulses, run_len, min_run;

    osc_source osc_u (.osc_o(osc_i));
    cpu_clock_generation_select dut_u (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .osc_i(osc_i),
        .long_reset_i(long_reset_i), .port0_upper_byte_i(port0_upper_byte_i),
        .cfg_load_i(cfg_load_i), .reset_control_register_i(reset_control_register_i),
        .reset_config_latch_o(latch), .clock_mode_select_o(mode),
        .cpu_clk_o(cpu_clk), .half_period_edge_o(hp_edge));

    // Phase lengths and edge counts, watched on every rising system clock edge
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        cpu_q <= cpu_clk;
        run_len <= (cpu_q !== cpu_clk) ? 1 : run_len + 1;
        if (cpu_q !== cpu_clk) begin
            toggles <= toggles + 1;
            if (run_len < min_run)
                min_run <= run_len;
        end
        if (hp_edge === 1'b1)
            pulses <= pulses + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            conclude();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input int tol);
        checks_done++;
        if (tol == 0 ? got !== exp : (got > exp + tol || got + tol < exp)) begin
            errors++;
            $display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic load_sw(input logic [2:0] m);
        @(posedge clk_sys_i);
        #1 reset_control_register_i = {m, 5'h15};
        cfg_load_i = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1 cfg_load_i = 1'b0;
        for (int i = 0; i < 400 && mode !== m; i++) @(posedge clk_sys_i);
        check(latch, {m, 5'h15}, 0);
        check(mode, m, 0);
    endtask

    // Edges over eight oscillator periods of 80 cycles
    task automatic rate(input logic [2:0] m, input int exp);
        load_sw(m);
        repeat (160) @(posedge clk_sys_i);
        #1 toggles = 0;
        pulses = 0;
        repeat (640) @(posedge clk_sys_i);
        #1 check(toggles, exp, 2);
        check(pulses, toggles, 1);
    endtask

    task automatic high_len(input int exp);
        int n;
        n = 0;
        while (cpu_clk !== 1'b0) @(negedge clk_sys_i);
        while (cpu_clk !== 1'b1) @(negedge clk_sys_i);
        while (cpu_clk === 1'b1) begin
            @(negedge clk_sys_i);
            n++;
        end
        check(n, exp, 0);
    endtask

    task automatic conclude();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        {rst_b_i, long_reset_i, cfg_load_i} = 3'h0;
        port0_upper_byte_i = 8'h00;
        reset_control_register_i = 8'h00;
        {errors, checks_done, cyc, toggles, pulses, run_len} = '0;
        min_run = 1000;
        cpu_q = 1'b0;
        repeat (6) @(posedge clk_sys_i);
        #1 rst_b_i = 1'b1;
        check(latch, CFG_RESET, 0);
        check(mode, MODE_X4, 0);
        repeat (4) @(posedge clk_sys_i);
        #1 port0_upper_byte_i = 8'h2C;
        long_reset_i = 1'b1;
        repeat (10) @(posedge clk_sys_i);
        #1 long_reset_i = 1'b0;
        repeat (200) @(posedge clk_sys_i);
        check(latch, 8'h2C, 0);
        check(mode, MODE_PRESCALE, 0);
        high_len(80);
        rate(MODE_X4, 64);
        rate(MODE_X3, 48);
        rate(MODE_X2, 32);
        rate(MODE_X5, 80);
        rate(MODE_DIRECT, 16);
        high_len(30);
        rate(MODE_X1P5, 24);
        rate(MODE_PRESCALE, 8);
        rate(MODE_X2P5, 40);
        check(min_run >= 3, 1, 0);
        conclude();
    end
endmodule
